// ### hw/link_exchange_map.svh
// Address, size and count constants of the shared link word area.
`ifndef LINK_EXCHANGE_MAP_SVH
`define LINK_EXCHANGE_MAP_SVH
`define LX_AREA_FIRST 16'd3100
`define LX_AREA_LAST 16'd3199
`define LX_AREA_WORDS 100
`define LX_ADDR_W 7
`define LX_WORD_W 16
`define LX_MAX_BLOCK 4'hA
`define LX_WC_DEFAULT 4'h0
`define LX_POLLED_MAX 8
`define LX_SRC_POLLING 4'h8
`define LX_FIFO_DEPTH 32
`define LX_RX_W 24
`endif

// ### hw/link_exchange_pkg.sv
// Types shared by the link word exchange design.
package link_exchange_pkg;
`include "link_exchange_map.svh"
  typedef enum logic {LINK_COMPLETE = 1'b0, LINK_POLLING = 1'b1} link_mode_e;
  typedef enum logic [1:0] {POLL_IDLE = 2'b00, POLL_WAIT = 2'b01} poll_state_e;
  typedef logic [`LX_ADDR_W-1:0] addr_t;
  typedef logic [`LX_WORD_W-1:0] word_t;
  typedef struct packed {
    logic [`LX_AREA_WORDS-1:0][`LX_WORD_W-1:0] mem;
    logic [`LX_AREA_WORDS-1:0] defined;
    logic [9:0] cfg;
    logic [`LX_POLLED_MAX-1:0] present;
    logic [2:0] cur;
    poll_state_e ps;
    logic poll_strobe;
    logic [2:0] poll_unit;
    logic poll_term;
    logic [3:0] tx_idx;
    logic tx_valid;
    logic tx_last;
    word_t tx_word;
    word_t rd_data;
    logic rd_def;
  } lx_state_s;
endpackage

// ### hw/serial_link_word_exchange.sv
// Shared word area of one node on a cyclic serial word exchange network, with its receive FIFO.
`timescale 1ns/100ps

module lx_fifo #(
  parameter int W = 24,
  parameter int D = 32
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic in_rdy;
  } fifo_s;
  fifo_s q;
  fifo_s d;
  logic push;
  logic pop;

  assign out_valid_out = (q.cnt != '0);
  assign out_data_out = q.mem[q.rp];
  assign in_ready_out = q.in_rdy;
  assign push = in_valid_in && q.in_rdy;
  assign pop = out_valid_out && out_ready_in;

  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wp] = in_data_in;
      d.wp = AW'(q.wp + 1'b1);
    end
    if (pop)
    begin
      d.rp = AW'(q.rp + 1'b1);
    end
    d.cnt = (AW+1)'(q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    // Ready is registered so that the source sees back-pressure from a flop.
    d.in_rdy = (d.cnt != (AW+1)'(D));
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end
endmodule // lx_fifo

module serial_link_word_exchange (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic is_polling_in,
  input wire link_exchange_pkg::link_mode_e link_mode_in,
  input wire logic [3:0] word_count_in,
  input wire logic [2:0] highest_unit_in,
  input wire logic [2:0] own_unit_in,
  input wire logic [7:0] terminal_mask_in,
  input wire logic rx_valid_in,
  input wire logic [3:0] rx_src_in,
  input wire logic [3:0] rx_idx_in,
  input wire link_exchange_pkg::word_t rx_word_in,
  output logic rx_ready_out,
  input wire logic local_wr_in,
  input wire logic [3:0] local_idx_in,
  input wire link_exchange_pkg::word_t local_word_in,
  input wire link_exchange_pkg::addr_t rd_addr_in,
  output link_exchange_pkg::word_t rd_data_out,
  output logic rd_defined_out,
  input wire logic poll_ready_in,
  input wire logic poll_done_in,
  input wire logic poll_absent_in,
  output logic poll_strobe_out,
  output logic [2:0] poll_unit_out,
  output logic poll_terminal_out,
  output logic [7:0] present_out,
  input wire logic tx_start_in,
  input wire logic tx_ready_in,
  output logic tx_valid_out,
  output link_exchange_pkg::word_t tx_word_out,
  output logic tx_last_out
);
  import link_exchange_pkg::*;

  lx_state_s q;
  lx_state_s d;
  logic [`LX_RX_W-1:0] f_data;
  logic f_valid;
  logic f_ready;
  logic [3:0] n_words;
  addr_t own_base;
  addr_t rx_base;
  logic rx_keep;
  logic [2:0] rx_unit;
  addr_t clr_base;
  addr_t tx_addr;

  // Local writes win the single write slot; the FIFO absorbs the stall.
  assign f_ready = !local_wr_in;

  lx_fifo #(
    .W(`LX_RX_W),
    .D(`LX_FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .in_valid_in(rx_valid_in),
    .in_data_in({rx_src_in, rx_idx_in, rx_word_in}),
    .in_ready_out(rx_ready_out),
    .out_valid_out(f_valid),
    .out_data_out(f_data),
    .out_ready_in(f_ready)
  );

  always_comb
  begin
    n_words = (word_count_in == `LX_WC_DEFAULT || word_count_in > `LX_MAX_BLOCK) ? `LX_MAX_BLOCK : word_count_in;
    rx_unit = f_data[22:20];
    // Own block address: block 0 on the polling node, common polled block in polling mode, per-unit slot otherwise.
    if (is_polling_in)
    begin
      own_base = '0;
    end
    else if (link_mode_in == LINK_POLLING)
    begin
      own_base = addr_t'(n_words);
    end
    else
    begin
      own_base = addr_t'(n_words) * addr_t'({1'b0, own_unit_in} + 4'h1);
    end
    rx_keep = 1'b0;
    rx_base = '0;
    if (f_data[19:16] < n_words)
    begin
      if (f_data[23:20] == `LX_SRC_POLLING)
      begin
        rx_keep = !is_polling_in;
      end
      else if (!f_data[23] && !terminal_mask_in[rx_unit] && rx_unit <= highest_unit_in)
      begin
        rx_base = addr_t'(n_words) * addr_t'({1'b0, rx_unit} + 4'h1);
        if (link_mode_in == LINK_COMPLETE)
        begin
          rx_keep = is_polling_in || rx_unit != own_unit_in;
        end
        else
        begin
          rx_keep = is_polling_in;
        end
      end
    end
    clr_base = addr_t'(n_words) * addr_t'({1'b0, q.cur} + 4'h1);
    tx_addr = addr_t'(own_base + addr_t'(q.tx_idx));
  end

  always_comb
  begin
    d = q;
    d.poll_strobe = 1'b0;
    d.cfg = {is_polling_in, link_mode_in, word_count_in, own_unit_in, 1'b0};
    // A changed layout makes every copied word stale.
    if (d.cfg != q.cfg)
    begin
      d.defined = '0;
    end
    if (local_wr_in && local_idx_in < n_words)
    begin
      d.mem[addr_t'(own_base + addr_t'(local_idx_in))] = local_word_in;
      d.defined[addr_t'(own_base + addr_t'(local_idx_in))] = 1'b1;
    end
    else if (f_valid && rx_keep)
    begin
      d.mem[addr_t'(rx_base + addr_t'(f_data[19:16]))] = f_data[15:0];
      d.defined[addr_t'(rx_base + addr_t'(f_data[19:16]))] = 1'b1;
      if (is_polling_in && f_data[23:20] != `LX_SRC_POLLING)
      begin
        d.present[rx_unit] = 1'b1;
      end
    end
    // Polling sequence over units 0 to the highest configured one.
    unique case (q.ps)
      POLL_IDLE:
      begin
        if (q.cur > highest_unit_in)
        begin
          d.cur = '0;
        end
        else if (is_polling_in && poll_ready_in)
        begin
          d.poll_strobe = 1'b1;
          d.poll_unit = q.cur;
          d.poll_term = terminal_mask_in[q.cur];
          d.ps = POLL_WAIT;
        end
      end
      POLL_WAIT:
      begin
        if (poll_done_in)
        begin
          if (poll_absent_in || terminal_mask_in[q.cur])
          begin
            d.present[q.cur] = 1'b0;
            for (int w = 0; w < `LX_AREA_WORDS; w++)
            begin
              if (w >= clr_base && w < clr_base + n_words)
              begin
                d.defined[w] = 1'b0;
              end
            end
          end
          d.cur = (q.cur >= highest_unit_in) ? 3'h0 : 3'(q.cur + 3'h1);
          d.ps = POLL_IDLE;
        end
      end
      default:
      begin
        d.ps = POLL_IDLE;
      end
    endcase
    for (int u = 0; u < `LX_POLLED_MAX; u++)
    begin
      if (u > highest_unit_in || !is_polling_in)
      begin
        d.present[u] = 1'b0;
      end
    end
    // Transmit our own block, one word per accepted handshake.
    if (!q.tx_valid)
    begin
      if (tx_start_in)
      begin
        d.tx_valid = 1'b1;
        d.tx_idx = 4'h0;
        d.tx_word = q.mem[own_base];
        d.tx_last = (n_words == 4'h1);
      end
    end
    else if (tx_ready_in)
    begin
      if (q.tx_last)
      begin
        d.tx_valid = 1'b0;
        d.tx_last = 1'b0;
      end
      else
      begin
        d.tx_idx = 4'(q.tx_idx + 4'h1);
        d.tx_word = q.mem[addr_t'(tx_addr + addr_t'(1))];
        d.tx_last = (4'(q.tx_idx + 4'h2) == n_words);
      end
    end
    // Words outside the area read as zero and undefined.
    if (rd_addr_in < `LX_AREA_WORDS)
    begin
      d.rd_data = q.mem[rd_addr_in];
      d.rd_def = q.defined[rd_addr_in];
    end
    else
    begin
      d.rd_data = '0;
      d.rd_def = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign rd_data_out = q.rd_data;
  assign rd_defined_out = q.rd_def;
  assign poll_strobe_out = q.poll_strobe;
  assign poll_unit_out = q.poll_unit;
  assign poll_terminal_out = q.poll_term;
  assign present_out = q.present;
  assign tx_valid_out = q.tx_valid;
  assign tx_word_out = q.tx_word;
  assign tx_last_out = q.tx_last;
endmodule // serial_link_word_exchange

// ### tb/lx_monitor.sv
// Port checker for one shared word exchange node.
`timescale 1ns/100ps
module lx_monitor (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic is_polling_in,
  input wire logic [2:0] highest_unit_in,
  input wire logic [7:0] terminal_mask_in,
  input wire link_exchange_pkg::addr_t rd_addr_in,
  input wire link_exchange_pkg::word_t rd_data_out,
  input wire logic rd_defined_out,
  input wire logic poll_done_in,
  input wire logic poll_absent_in,
  input wire logic poll_strobe_out,
  input wire logic [2:0] poll_unit_out,
  input wire logic poll_terminal_out,
  input wire logic [7:0] present_out,
  input wire logic tx_start_in,
  input wire logic tx_ready_in,
  input wire logic tx_valid_out,
  input wire link_exchange_pkg::word_t tx_word_out,
  input wire logic tx_last_out
);
  import link_exchange_pkg::*;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  a_strobe_pulse: assert property (poll_strobe_out |=> !poll_strobe_out) else $error("poll strobe too long");
  a_poll_range: assert property (poll_strobe_out |-> poll_unit_out <= highest_unit_in) else $error("unit polled");
  a_poll_role: assert property (poll_strobe_out |-> is_polling_in) else $error("polled node polls");
  a_term_flag: assert property (poll_strobe_out |-> poll_terminal_out == terminal_mask_in[poll_unit_out])
    else $error("terminal flag wrong");
  a_gone_clear: assert property (poll_done_in && (poll_absent_in || poll_terminal_out)
    |=> !present_out[$past(poll_unit_out)]) else $error("present kept");
  a_high_undef: assert property (rd_addr_in > 7'h63 |=> !rd_defined_out && rd_data_out == 16'h0000)
    else $error("read past area");
  a_tx_begin: assert property (tx_start_in && !tx_valid_out |=> tx_valid_out) else $error("tx not started");
  a_tx_hold: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_word_out))
    else $error("tx word dropped");
  a_tx_end: assert property (tx_valid_out && tx_ready_in && tx_last_out |=> !tx_valid_out) else $error("tx overrun");
  c_term_poll: cover property (poll_strobe_out && poll_terminal_out);
  c_absent: cover property (poll_done_in && poll_absent_in);
  c_tx_last: cover property (tx_valid_out && tx_ready_in && tx_last_out);
endmodule // lx_monitor
bind serial_link_word_exchange lx_monitor mon (.*);

// ### tb/lx_partner.sv
// Link layer stand-in: answers polls after a random delay and throttles the transmit sink.
`timescale 1ns/100ps
module lx_partner (
  input wire logic core_clk_in,
  input wire logic en_in,
  input wire logic poll_strobe_in,
  input wire logic [2:0] poll_unit_in,
  input wire logic [7:0] absent_in,
  output logic poll_ready_out,
  output logic poll_done_out,
  output logic poll_absent_out,
  output logic tx_ready_out,
  output int polls_out
);
  always @(negedge core_clk_in) tx_ready_out <= 1'($urandom_range(0, 1));
  always @(negedge core_clk_in) poll_ready_out <= en_in;
  initial
  begin
    {poll_done_out, poll_absent_out} = 2'h0;
    polls_out = 0;
    forever
    begin
      @(posedge core_clk_in);
      if (poll_strobe_in === 1'b1)
      begin
        repeat ($urandom_range(1, 3)) @(negedge core_clk_in);
        // Only the addressed unit answers, so absence is judged per unit number.
        poll_done_out = 1'b1;
        poll_absent_out = absent_in[poll_unit_in];
        polls_out++;
        @(negedge core_clk_in);
        poll_done_out = 1'b0;
        poll_absent_out = ~poll_absent_out;
      end
    end
  end
endmodule // lx_partner

// ### tb/serial_link_word_exchange_tb.sv
// Self-checking bench for the shared word exchange node.
`timescale 1ns/100ps
`define CHK(n, e, s) begin check_count++; if ((e) !== (s)) begin err_total++; \
  $display("unexpected %s exp %0h got %0h", n, e, s); end end
module serial_link_word_exchange_tb;
  import link_exchange_pkg::*;
  logic core_clk_in = 0, rst_b_in = 0, is_polling_in = 1, rx_valid_in = 0, local_wr_in = 0, tx_start_in = 0, en = 0;
  link_mode_e link_mode_in = LINK_COMPLETE;
  logic [3:0] word_count_in = 4'h0, rx_src_in = 4'h0, rx_idx_in = 4'h0, local_idx_in = 4'h0;
  logic [2:0] highest_unit_in = 3'h3, own_unit_in = 3'h5, poll_unit_out;
  logic [7:0] terminal_mask_in = 8'h04, present_out;
  word_t rx_word_in = 16'h0000, local_word_in = 16'h0000, rd_data_out, tx_word_out;
  addr_t rd_addr_in = 7'h00;
  logic rx_ready_out, rd_defined_out, poll_ready_in, poll_done_in, poll_absent_in, poll_strobe_out;
  logic poll_terminal_out, tx_ready_in, tx_valid_out, tx_last_out;
  int err_total = 0, check_count = 0, cyc = 0, polls, n, k, m[100];
  bit d[100];
  always #2.5 core_clk_in = ~core_clk_in;
  serial_link_word_exchange dut (.*);
  lx_partner far (.core_clk_in(core_clk_in), .en_in(en), .poll_strobe_in(poll_strobe_out),
    .poll_unit_in(poll_unit_out), .absent_in(8'h02), .poll_ready_out(poll_ready_in),
    .poll_done_out(poll_done_in), .poll_absent_out(poll_absent_in), .tx_ready_out(tx_ready_in), .polls_out(polls));
  function automatic bit ok(int s, int i);
    if (s == 8) return !is_polling_in && i < n;
    return s <= highest_unit_in && !terminal_mask_in[s] && i < n
      && (is_polling_in || (link_mode_in == LINK_COMPLETE && s != own_unit_in));
  endfunction
  function automatic int ob();
    return is_polling_in ? 0 : (link_mode_in == LINK_POLLING ? n : n * (own_unit_in + 1));
  endfunction
  function automatic int ad(int s, int i);
    return s == 8 ? i : n * (s + 1) + i;
  endfunction
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic send(int s, int i);
    @(negedge core_clk_in);
    rx_valid_in = 1;
    rx_src_in = 4'(s);
    rx_idx_in = 4'(i);
    rx_word_in = 16'($urandom);
    do @(posedge core_clk_in); while (rx_ready_out !== 1'b1);
    if (ok(s, i)) m[ad(s, i)] = rx_word_in;
    if (ok(s, i)) d[ad(s, i)] = 1;
  endtask
  task automatic rd(int a);
    bit e;
    @(negedge core_clk_in) rd_addr_in = 7'(a);
    @(negedge core_clk_in) e = a < 100 && d[a];
    `CHK("defined", e, rd_defined_out)
    if (e || a > 99) `CHK("data", e ? 16'(m[a]) : 16'h0000, rd_data_out)
  endtask
  always @(posedge core_clk_in)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      err_total++;
      finish_test;
    end
  end
  initial
  begin
    void'($urandom(15666));
    repeat (8) @(negedge core_clk_in);
    rst_b_in = 1;
    // Tests: polling node complete, polled node polling, polled node complete, polling node polling.
    for (int t = 0; t < 4; t++)
    begin
      @(negedge core_clk_in);
      n = 10;
      if (t > 0)
      begin
        n = $urandom_range(1, 10);
        is_polling_in = 1'(t == 3);
        link_mode_in = (t == 2) ? LINK_COMPLETE : LINK_POLLING;
        own_unit_in = 3'h1;
        word_count_in = 4'(n);
      end
      foreach (d[i]) d[i] = 0;
      repeat (3) @(negedge core_clk_in);
      for (int s = 0; s < 9; s++) for (int i = 0; i < 11; i++) send(s, i);
      @(negedge core_clk_in) rx_valid_in = 0;
      repeat (40) @(negedge core_clk_in);
      for (int i = 0; i < n; i++)
      begin
        @(negedge core_clk_in);
        k = ob() + i;
        local_idx_in = 4'(i);
        local_word_in = 16'($urandom);
        local_wr_in = 1;
        m[k] = local_word_in;
        d[k] = 1;
      end
      @(negedge core_clk_in) local_wr_in = 0;
      if (t == 0)
      begin
        en = 1;
        for (k = 0; k < 300 && polls < 5; k++) @(negedge core_clk_in);
        en = 0;
        repeat (10) @(negedge core_clk_in);
        // Unit one answered absent and unit two is a terminal, so both blocks drop out.
        for (int i = 0; i < 2 * n; i++) d[2 * n + i] = 0;
        `CHK("present", 8'h09, present_out)
      end
      for (int a = 0; a < 101; a++) rd(a == 100 ? 127 : a);
      @(negedge core_clk_in) tx_start_in = 1;
      @(negedge core_clk_in) tx_start_in = 0;
      k = 0;
      for (int c = 0; c < 300 && k < n; c++)
      begin
        @(posedge core_clk_in);
        if (tx_valid_out === 1'b1 && tx_ready_in === 1'b1)
        begin
          `CHK("tx word", 16'(m[ob() + k]), tx_word_out)
          `CHK("tx last", 1'(k == n - 1), tx_last_out)
          k++;
        end
      end
      `CHK("tx count", n, k)
      $display("test %0d done", t);
    end
    finish_test;
  end
endmodule // serial_link_word_exchange_tb
